// *** hdl/acq_trigger_control.sv ***
`timescale 1ns/10ps
`include "acq_consts.svh"
module acq_trigger_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire acq_pkg::acq_config_type cfg,
	input wire acq_pkg::acq_pins_type pins,
	input wire logic start,
	input wire logic stop,
	input wire logic soft_trigger,
	output acq_pkg::acq_events_type events
);
	import acq_pkg::*;

	typedef struct packed {
		acq_state_type fsm;
		logic [7:0] divider;
		logic [15:0] delay_left;
		logic [23:0] samples_left;
		logic [23:0] scans_done;
		logic [23:0] half_mark;
		logic [15:0] pre_left;
		logic pre_reached;
		logic [15:0] triggers_taken;
		logic soft_last;
		acq_events_type ev;
	} top_state_type;
	top_state_type state;
	top_state_type next_state;

	logic [6:0] edge_pulse;
	logic [6:0] edge_falling;
	logic timer_tick;
	logic conv_tick;
	logic delay_tick;
	logic trig_pulse;
	logic soft_pulse;
	logic unlimited;
	logic may_retrigger;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	// Only the digital trigger honours the polarity option; other pins act on rising edges.
	assign edge_falling = {1'b0, cfg.falling_edge_select, 5'b00000}; // [R2]

	edge_sync sync_inst (
		.clk(clk),
		.rst_n(rst_n),
		.pin(pins),
		.falling(edge_falling),
		.pulse(edge_pulse)
	);

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	// Bit order follows the pin struct: analog, digital, sync, aux0, aux1, gpc0, gpc1.
	assign timer_tick = (state.divider == `ZERO8);
	assign soft_pulse = soft_trigger & ~state.soft_last;

	always_comb begin
		unique case (cfg.trigger_source_control)
			TRIG_SOFT: trig_pulse = soft_pulse; // [R1]
			TRIG_ANALOG: trig_pulse = edge_pulse[6]; // [R1]
			TRIG_DIGITAL: trig_pulse = edge_pulse[5]; // [R1] [R2]
			TRIG_SYNC: trig_pulse = edge_pulse[4]; // [R1]
		endcase
		unique case (cfg.conversion_clock_select)
			CONV_TIMER: conv_tick = timer_tick; // [R3]
			CONV_AUX0: conv_tick = edge_pulse[3]; // [R3]
			CONV_SYNC: conv_tick = edge_pulse[4]; // [R3]
			CONV_AUX1: conv_tick = edge_pulse[2]; // [R3]
		endcase
		if (cfg.delay_unit_samples) begin
			delay_tick = conv_tick; // [R5]
		end else begin
			unique case (cfg.delay_source_select)
				DLY_TIMER: delay_tick = timer_tick; // [R4]
				DLY_AUX1: delay_tick = edge_pulse[2]; // [R4]
				DLY_GPC0: delay_tick = edge_pulse[1]; // [R4]
				DLY_GPC1: delay_tick = edge_pulse[0]; // [R4]
			endcase
		end
	end

	// Zero limit with re-trigger enabled means triggers never run out.
	assign unlimited = cfg.retrigger_enable && (cfg.retrigger_limit == `ZERO16); // [R8]
	assign may_retrigger = cfg.retrigger_enable
		&& (unlimited || (state.triggers_taken < cfg.retrigger_limit)); // [R7] [R8]

	// ----------------------------------------
	// Acquisition sequencer
	// ----------------------------------------
	// Events other than busy are single-cycle pulses; the internal timer is a divided enable.
	always_comb begin
		next_state = state;
		next_state.ev.acquisition_done_event = 1'b0;
		next_state.ev.half_buffer_event = 1'b0;
		next_state.ev.trigger_data_event = 1'b0;
		next_state.ev.sample_strobe = 1'b0;
		next_state.soft_last = soft_trigger;
		next_state.divider = timer_tick ? `TIMER_DIV : state.divider - 8'h01;
		unique case (state.fsm)
			ST_IDLE: begin
				if (start) begin
					next_state.fsm = ST_ARMED;
					next_state.pre_left = cfg.pre_count_value; // [R11]
					next_state.pre_reached = !cfg.pre_count_gate_enable
						|| (cfg.pre_count_value == `ZERO16); // [R10]
					next_state.triggers_taken = `ZERO16;
					next_state.scans_done = `ZERO24;
					next_state.half_mark = {1'b0, cfg.total_scan_count[23:1]}; // [R13]
				end
			end
			ST_ARMED: begin
				// Pre-count runs on conversions before the trigger is allowed.
				if (!state.pre_reached && conv_tick) begin
					next_state.pre_left = state.pre_left - `ONE16; // [R10]
					next_state.pre_reached = (state.pre_left == `ONE16); // [R10] [R11]
				end
				if (trig_pulse && state.pre_reached) begin // [R10]
					next_state.triggers_taken = state.triggers_taken + `ONE16;
					next_state.ev.trigger_data_event = 1'b1; // [R15]
					next_state.delay_left = cfg.trigger_delay_count;
					next_state.samples_left = cfg.post_trigger_count; // [R9]
					if (cfg.mode == MODE_DELAY && cfg.trigger_delay_count != `ZERO16) begin
						next_state.fsm = ST_DELAY; // [R6]
					end else begin
						next_state.fsm = ST_ACQUIRE;
					end
				end
			end
			ST_DELAY: begin
				// Delay ticks are discarded, not stored.
				if (delay_tick) begin
					next_state.delay_left = state.delay_left - `ONE16; // [R6]
					if (state.delay_left == `ONE16) begin
						next_state.fsm = ST_ACQUIRE; // [R6]
					end
				end
			end
			ST_ACQUIRE: begin
				if (conv_tick) begin
					next_state.ev.sample_strobe = 1'b1;
					next_state.scans_done = state.scans_done + `ONE24;
					next_state.samples_left = state.samples_left - `ONE24;
					if (state.scans_done + `ONE24 == state.half_mark
						|| state.scans_done + `ONE24 == cfg.total_scan_count) begin
						next_state.ev.half_buffer_event = 1'b1; // [R13]
					end
					if (state.scans_done + `ONE24 == cfg.total_scan_count) begin
						next_state.scans_done = `ZERO24;
						if (!unlimited) begin
							next_state.fsm = ST_DONE; // [R17]
						end
					end else if (cfg.mode == MODE_MIDDLE
						&& state.samples_left == `ONE24) begin
						next_state.fsm = ST_DONE; // [R9] [R12]
					end else if (cfg.mode != MODE_MIDDLE && may_retrigger
						&& !cfg.delay_unit_samples && trig_pulse) begin
						next_state.fsm = ST_ARMED; // [R7]
					end
				end
			end
			ST_DONE: begin
				next_state.ev.acquisition_done_event = 1'b1; // [R14]
				next_state.fsm = ST_IDLE;
			end
			default: next_state.fsm = ST_IDLE;
		endcase
		if (stop && state.fsm != ST_IDLE && state.fsm != ST_DONE) begin
			next_state.fsm = ST_DONE;
		end
		next_state.ev.busy = (next_state.fsm != ST_IDLE);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign events = state.ev;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_done_follows: assert property (@(posedge clk) disable iff (!rst_n)
		state.fsm == ST_DONE |=> events.acquisition_done_event && !events.busy)
		else $error("completion event missing"); // [R14]
	a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		(state.fsm == ST_ARMED && !state.pre_reached) |=> !events.trigger_data_event)
		else $error("trigger taken before pre-count"); // [R10]
	a_trigger_event: assert property (@(posedge clk) disable iff (!rst_n)
		(state.fsm == ST_ARMED && state.pre_reached && trig_pulse && !stop)
		|=> events.trigger_data_event) else $error("trigger event missing"); // [R15]
	a_delay_discards: assert property (@(posedge clk) disable iff (!rst_n)
		state.fsm == ST_DELAY |=> !events.sample_strobe)
		else $error("sample during delay"); // [R6]
	a_no_retrigger: assert property (@(posedge clk) disable iff (!rst_n)
		(state.fsm == ST_ACQUIRE && !cfg.retrigger_enable) |=> state.fsm != ST_ARMED)
		else $error("re-trigger while disabled"); // [R7]
	a_limit_held: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.retrigger_enable && !unlimited) |-> state.triggers_taken <= cfg.retrigger_limit)
		else $error("trigger limit exceeded"); // [R8]
	a_soft_default: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.trigger_source_control == TRIG_SOFT && !soft_pulse) |-> !trig_pulse)
		else $error("spurious soft trigger"); // [R1]
	a_timer_pace: assert property (@(posedge clk) disable iff (!rst_n)
		timer_tick |=> !timer_tick [*8]) else $error("timer tick too fast"); // [R3]
endmodule

// *** hdl/acq_consts.svh ***
// Functional notes
// R1: Trigger source is software (default), analog pin, digital pin or sync bus.
// R2: Digital trigger acts on rising edge by default, falling edge when selected.
// R3: Conversion pacing from timer (default), aux input zero, sync bus or aux input one.
// R4: Delay counter counts timer (default), aux input one, or counter 0/1 output.
// R5: Delay counted in samples or timebase ticks; ticks is the default.
// R6: After each accepted trigger, discard programmed 16-bit delay count before acquiring. The code applies the delay in delay mode only.
// R7: Re-trigger enable off (default) honours only the first trigger.
// R8: With re-trigger on, accept up to 16-bit limit; zero means without end. The code never re-triggers in middle mode or with the delay counted in samples.
// R9: Middle mode acquires programmed 24-bit count of samples after the trigger.
// R10: Pre-count enabled ignores triggers until terminal count; disabled honours at once.
// R11: Pre-count terminal value is 16 bits, zero to 65535.
// R12: Host programs total scan count as post-trigger count plus pre-count.
// R13: Signal an event when each half of the circular buffer fills.
// R14: Signal an event when the asynchronous acquisition completes.
// R15: Signal an event when data of the next trigger is available.
// R16: Synchronise trigger and aux pins, one single-cycle pulse per qualifying edge.
// R17: End and signal completion at total scan count unless unlimited re-trigger active.
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH
`define ZERO16 16'h0000
`define ZERO24 24'h000000
`define ONE16 16'h0001
`define ONE24 24'h000001
`define TIMER_DIV 8'h63
`define ZERO8 8'h00
`endif

// *** hdl/acq_pkg.sv ***
package acq_pkg;
	typedef enum logic [1:0] {TRIG_SOFT = 2'b00, TRIG_ANALOG = 2'b01, TRIG_DIGITAL = 2'b10,
		TRIG_SYNC = 2'b11} trigger_source_type;
	typedef enum logic [1:0] {CONV_TIMER = 2'b00, CONV_AUX0 = 2'b01, CONV_SYNC = 2'b10,
		CONV_AUX1 = 2'b11} conversion_clock_type;
	typedef enum logic [1:0] {DLY_TIMER = 2'b00, DLY_AUX1 = 2'b01, DLY_GPC0 = 2'b10,
		DLY_GPC1 = 2'b11} delay_source_type;
	typedef enum logic [1:0] {MODE_POST = 2'b00, MODE_DELAY = 2'b01,
		MODE_MIDDLE = 2'b11} trigger_mode_type;
	typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ARMED = 3'b001, ST_DELAY = 3'b011,
		ST_ACQUIRE = 3'b010, ST_DONE = 3'b110} acq_state_type;
	typedef struct packed {
		trigger_mode_type mode;
		trigger_source_type trigger_source_control;
		logic falling_edge_select;
		conversion_clock_type conversion_clock_select;
		delay_source_type delay_source_select;
		logic delay_unit_samples;
		logic [15:0] trigger_delay_count;
		logic retrigger_enable;
		logic [15:0] retrigger_limit;
		logic [23:0] post_trigger_count;
		logic pre_count_gate_enable;
		logic [15:0] pre_count_value;
		logic [23:0] total_scan_count;
	} acq_config_type;
	typedef struct packed {
		logic analog_trigger;
		logic digital_trigger;
		logic system_sync_bus;
		logic aux_input_zero;
		logic aux_input_one;
		logic gp_counter0_output;
		logic gp_counter1_output;
	} acq_pins_type;
	typedef struct packed {
		logic acquisition_done_event;
		logic half_buffer_event;
		logic trigger_data_event;
		logic sample_strobe;
		logic busy;
	} acq_events_type;
endpackage

// *** hdl/edge_sync.sv ***
`timescale 1ns/10ps
`include "acq_consts.svh"
module edge_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [6:0] pin,
	input wire logic [6:0] falling,
	output logic [6:0] pulse
);
	typedef struct packed {
		logic [6:0] meta;
		logic [6:0] sync;
		logic [6:0] last;
		logic [6:0] pulse;
	} sync_state_type;
	sync_state_type state;
	sync_state_type next_state;

	// ----------------------------------------
	// Two-stage synchroniser and edge detection
	// ----------------------------------------
	// Only the second stage feeds the edge detector, keeping metastability out of logic.
	always_comb begin
		next_state = state;
		next_state.meta = pin;
		next_state.sync = state.meta;
		next_state.last = state.sync;
		for (int i = 0; i < 7; i++) begin
			next_state.pulse[i] = falling[i] ? (state.last[i] & ~state.sync[i])
				: (~state.last[i] & state.sync[i]); // [R16]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pulse = state.pulse;

	// Each edge of the selected polarity on the synchronised level yields exactly one pulse.
	a_single_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		state.pulse[5] |=> !state.pulse[5]) else $error("trigger pulse longer than a cycle"); // [R16]
endmodule

// *** verif/acq_pins_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Far-side pin model
// ----------------------------------------
module acq_pins_model (
	input wire logic clk,
	output acq_pkg::acq_pins_type pins
);
	import acq_pkg::*;
	// All pins rest low until a scenario moves them.
	initial begin
		pins = '0;
	end
	// Levels move at the falling edge so the design never samples mid-change.
	task automatic set_pin(input int idx, input logic v);
		@(negedge clk);
		pins[idx] = v;
	endtask
	// An external conversion clock that stands still between bursts.
	task automatic pulses(input int idx, input int n);
		repeat (n) begin
			set_pin(idx, 1'b1);
			repeat (9) @(negedge clk);
			set_pin(idx, 1'b0);
			repeat (9) @(negedge clk);
		end
	endtask
endmodule

// *** verif/acq_trigger_control_tb.sv ***
`timescale 1ns/10ps
module acq_trigger_control_tb;
	import acq_pkg::*;
	typedef struct packed {
		trigger_source_type src;
		logic fall;
		logic [3:0] pin;
		logic lvl0;
		logic hit_exp;
	} row_type;
	logic clk, rst_n, start, stop, soft_trigger, hit;
	acq_config_type cfg;
	acq_pins_type pins;
	acq_events_type events;
	int err_count = 0, tests_run = 0, cycles = 0, ns, nh, nt, gap;
	row_type rows[8];
	acq_pins_model i_model (.clk(clk), .pins(pins));
	acq_trigger_control i_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .pins(pins), .start(start),
		.stop(stop), .soft_trigger(soft_trigger), .events(events));
	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	// The clock toggles every half period.
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// The whole run needs about 4000 cycles, so 60000 means a hang.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			summarize();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	// Pulse start, soft trigger or stop for one cycle.
	task automatic kick(input int which);
		@(negedge clk);
		start = (which == 0);
		soft_trigger = (which == 1);
		stop = (which == 2);
		@(negedge clk);
		{start, soft_trigger, stop} = 3'h0;
	endtask
	// An event raised at the edge just before the call still stands, so look at it first.
	task automatic wait_for(input int b, input int lim, output logic h, output int n);
		h = 0;
		for (n = 0; n <= lim; n++) begin
			if (n > 0) begin
				@(posedge clk);
				#1;
			end
			if (events[b] === 1'b1) begin
				h = 1;
				break;
			end
		end
	endtask
	task automatic run_to_done(input int lim);
		ns = 0;
		nh = 0;
		nt = 0;
		repeat (lim) begin
			@(posedge clk);
			#1;
			ns += events.sample_strobe;
			nh += events.half_buffer_event;
			nt += events.trigger_data_event;
			if (events.acquisition_done_event === 1'b1) break;
		end
	endtask
	task automatic go();
		kick(0);
		repeat (5) @(negedge clk);
		kick(1);
		wait_for(2, 10, hit, gap);
	endtask
	task automatic base_cfg();
		cfg = '0;
		cfg.total_scan_count = 24'h000002;
	endtask
	task automatic summarize();
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Table rows first, then the awkward cases by hand.
	initial begin
		{rst_n, start, stop, soft_trigger} = 4'h0;
		base_cfg();
		rows = '{'{TRIG_SOFT, 0, 7, 0, 1}, '{TRIG_ANALOG, 0, 6, 0, 1}, '{TRIG_ANALOG, 0, 5, 0, 0},
			'{TRIG_DIGITAL, 0, 5, 0, 1}, '{TRIG_DIGITAL, 0, 5, 1, 0}, '{TRIG_DIGITAL, 1, 5, 1, 1},
			'{TRIG_DIGITAL, 1, 5, 0, 0}, '{TRIG_SYNC, 0, 4, 0, 1}};
		repeat (10) @(negedge clk);
		check("events_in_reset", events, 0);
		rst_n = 1;
		foreach (rows[i]) begin
			base_cfg();
			cfg.trigger_source_control = rows[i].src;
			cfg.falling_edge_select = rows[i].fall;
			if (rows[i].pin != 7) i_model.set_pin(rows[i].pin, rows[i].lvl0);
			repeat (4) @(negedge clk);
			kick(0);
			repeat (5) @(negedge clk);
			if (rows[i].pin == 7) kick(1);
			else i_model.set_pin(rows[i].pin, ~rows[i].lvl0);
			wait_for(2, 10, hit, gap);
			check("trigger_taken", hit, rows[i].hit_exp);
			if (hit) begin
				run_to_done(1000);
				check("samples", ns, 2);
				check("halves", nh, 2);
			end else begin
				kick(2);
				wait_for(4, 10, hit, gap);
			end
			@(posedge clk);
			#1;
			check("idle_after", events.busy, 0);
			if (rows[i].pin != 7) i_model.set_pin(rows[i].pin, 1'b0);
			$display("row %0d finished", i);
		end
		base_cfg();
		cfg.mode = MODE_DELAY;
		cfg.trigger_delay_count = 16'h0003;
		go();
		wait_for(1, 1000, hit, gap);
		check("delay_gap", gap > 299, 1);
		run_to_done(1000);
		$display("delay test finished");
		base_cfg();
		cfg.total_scan_count = 24'h000004;
		go();
		repeat (150) @(negedge clk);
		kick(1);
		run_to_done(1000);
		check("second_trigger", nt, 0);
		$display("single trigger test finished");
		base_cfg();
		cfg.retrigger_enable = 1'b1;
		go();
		repeat (600) @(negedge clk);
		check("unlimited_runs", events.busy, 1);
		kick(2);
		wait_for(4, 10, hit, gap);
		check("stop_done", hit, 1);
		$display("unlimited test finished");
		base_cfg();
		cfg.mode = MODE_MIDDLE;
		cfg.pre_count_gate_enable = 1'b1;
		cfg.pre_count_value = 16'h0003;
		cfg.post_trigger_count = 24'h000002;
		cfg.total_scan_count = 24'h000005;
		go();
		check("gated_trigger", hit, 0);
		repeat (450) @(negedge clk);
		kick(1);
		wait_for(2, 10, hit, gap);
		check("open_trigger", hit, 1);
		run_to_done(1000);
		check("middle_samples", ns, 2);
		$display("pre-count test finished");
		base_cfg();
		cfg.conversion_clock_select = CONV_AUX0;
		go();
		fork
			i_model.pulses(3, 2);
			run_to_done(60);
		join
		check("aux_samples", ns, 2);
		$display("pacing test finished");
		base_cfg();
		cfg.mode = MODE_DELAY;
		cfg.delay_source_select = DLY_AUX1;
		cfg.trigger_delay_count = 16'h0002;
		go();
		run_to_done(300);
		check("delay_held", ns, 0);
		i_model.pulses(2, 2);
		run_to_done(1000);
		check("delay_released", ns, 2);
		$display("delay source test finished");
		summarize();
	end
endmodule
